// >>> shared/csp_pkg.sv
// Purpose: Shared constants and types for the card SPI host port
// Assumes: 50 MHz host bus clock, byte-wide registers
// Notes: Offsets are full host bus addresses
package csp_pkg;

  // Register addresses
  localparam logic [15:0] CSP_ADDR_EXCHANGE = 16'hdf10;
  localparam logic [15:0] CSP_ADDR_CONTROL = 16'hdf11;
  localparam logic [15:0] CSP_ADDR_STATUS = 16'hdf12;

  // Control field positions
  localparam int CSP_CTL_DISABLE = 7;
  localparam int CSP_CTL_RD_TRIG = 6;
  localparam int CSP_CTL_EXT_OFF = 5;
  localparam int CSP_CTL_SEL_HI = 4;
  localparam int CSP_CTL_FAST = 2;
  localparam int CSP_CTL_SEL_LO = 1;
  localparam int CSP_CTL_BOOT_OFF = 0;
  localparam logic [7:0] CSP_CTL_RESET = 8'h00;

  // Status field positions
  localparam int CSP_ST_JUMPER = 5;
  localparam int CSP_ST_WPROT = 4;
  localparam int CSP_ST_NOCARD = 3;
  localparam int CSP_ST_EXROM = 2;
  localparam int CSP_ST_GAME = 1;
  localparam int CSP_ST_BUSY = 0;

  // Target select codes, {bit4, bit1}
  localparam logic [1:0] CSP_SEL_CARD = 2'h0;
  localparam logic [1:0] CSP_SEL_NONE = 2'h1;
  localparam logic [1:0] CSP_SEL_FLASH = 2'h2;
  localparam logic [1:0] CSP_SEL_RTC = 2'h3;

  // Byte sent when a read triggers a transfer
  localparam logic [7:0] CSP_FILL_BYTE = 8'hff;
  localparam logic [7:0] CSP_RX_RESET = 8'hff;

  // Clock rates and derived half periods (rounded up, rate never exceeded)
  localparam int CSP_MCLK_HZ = 50000000;
  localparam int CSP_SLOW_HZ = 250000;
  localparam int CSP_FAST_HZ = 8000000;
  localparam int CSP_HALF_SLOW_I = (CSP_MCLK_HZ + 2 * CSP_SLOW_HZ - 1) / (2 * CSP_SLOW_HZ);
  localparam int CSP_HALF_FAST_I = (CSP_MCLK_HZ + 2 * CSP_FAST_HZ - 1) / (2 * CSP_FAST_HZ);
  localparam logic [7:0] CSP_HALF_SLOW = CSP_HALF_SLOW_I[7:0];
  localparam logic [7:0] CSP_HALF_FAST = CSP_HALF_FAST_I[7:0];
  localparam logic [2:0] CSP_LAST_BIT = 3'h7;

  // Shifter states
  typedef enum logic [0:0] {CSP_IDLE, CSP_SHIFT} csp_state_e;

endpackage : csp_pkg

// >>> logic/csp_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_mclk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } csp_sync_s;

  csp_sync_s cur_ff;
  csp_sync_s nxt_st;

  // Both stages, every bit at once
  always_comb
  begin
    nxt_st.meta = i_async;
    nxt_st.sync = cur_ff.meta;
  end

  // State register
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_st;
  end

  assign o_sync = cur_ff.sync;

endmodule : csp_sync
`default_nettype wire

// >>> logic/csp_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module csp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } csp_fifo_s;

  csp_fifo_s cur_ff;
  csp_fifo_s nxt_st;
  logic push;
  logic pop;

  // Handshake terms
  assign o_in_ready = (cur_ff.count != FULL_CNT);
  assign o_out_valid = (cur_ff.count != '0);
  assign o_out_data = cur_ff.mem[cur_ff.rd_ptr];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Pointer and storage update
  always_comb
  begin
    nxt_st = cur_ff;
    if (push)
    begin
      nxt_st.mem[cur_ff.wr_ptr] = i_in_data;
      nxt_st.wr_ptr = cur_ff.wr_ptr + 1'b1;
    end
    if (pop)
      nxt_st.rd_ptr = cur_ff.rd_ptr + 1'b1;
    case ({push, pop})
      2'b10: nxt_st.count = cur_ff.count + 1'b1;
      2'b01: nxt_st.count = cur_ff.count - 1'b1;
      default: nxt_st.count = cur_ff.count;
    endcase
  end

  // State register
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_st;
  end

endmodule : csp_fifo
`default_nettype wire

// >>> logic/csp_port.sv
// Purpose: Memory-mapped SPI host port for card, flash ROM and clock chip
// Assumes: i_wr and i_rd are one-cycle strobes on i_mclk; pins are asynchronous
// Notes: Outgoing bytes queue in a 16-entry FIFO ahead of the shifter
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RULE1) Writing the exchange register sends a byte; reading returns last received byte.
// (RULE2) Control bit 7 disables the port when set; changeable only while unlocked.
// (RULE3) Control bit 6 picks trigger: 0 write starts transfer, 1 read starts.
// (RULE4) Control bit 5 set keeps external ROM off regardless.
// (RULE5) Control bits 4,1 pick card, nothing, flash or clock chip select.
// (RULE6) Control bit 2 picks 250 kHz when 0, 8 MHz when 1.
// (RULE7) Control bit 0 clear maps boot ROM; set removes it, external ROM active.
// (RULE8) Status register is read-only; writes change nothing.
// (RULE9) Status bit 5 always reads 0.
// (RULE10) Status bit 4 shows card write protect, 1 when protected.
// (RULE11) Status bit 3 reads 1 when slot is empty.
// (RULE12) Status bit 0 shows busy in slow mode; host polls before next access.
// (RULE13) Bytes shift MSB first in mode 0, eight clocks per byte.
// (RULE14) Reset leaves clock low, selects off, busy clear, control zero.
module csp_port
  import csp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and asynchronous reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host register bus
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_host_wait,
  // Lock level and ROM banking
  input wire logic i_port_unlock,
  output logic o_boot_rom_map,
  output logic o_ext_rom_en,
  // SPI link and chip selects
  output logic o_spi_sck,
  output logic o_spi_mosi,
  input wire logic i_spi_miso,
  output logic o_card_cs_n,
  output logic o_flash_cs_n,
  output logic o_rtc_cs_n,
  // Slot and cartridge lines, asynchronous
  input wire logic i_card_wprot,
  input wire logic i_card_absent,
  input wire logic i_exrom_line,
  input wire logic i_game_line
);

  // Whole block state, registered as one word
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rx;
    logic [7:0] sh;
    logic [7:0] rdata;
    logic [7:0] cnt;
    logic [2:0] bitn;
    logic sck;
    logic mosi;
    logic [2:0] cs_n;
    csp_state_e state;
  } csp_port_s;

  // Registered state and its next value
  csp_port_s cur_ff;
  csp_port_s nxt_st;

  // Synchronised pin levels
  logic miso_s;
  logic wprot_s;
  logic absent_s;
  logic exrom_s;
  logic game_s;
  logic unlock_s;

  // Register decode and trigger
  logic hit_xchg;
  logic hit_ctl;
  logic hit_st;
  logic enabled;

  // Queue handshake
  logic push_valid;
  logic push_ready;
  logic [7:0] push_data;
  logic q_valid;
  logic q_ready;
  logic [7:0] q_data;

  // Rate, status and select
  logic [7:0] half;
  logic [7:0] status;
  logic [1:0] sel;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Unlock level crosses too; control writes see it two edges late
  csp_sync #(
    .W(6)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_spi_miso, i_card_wprot, i_card_absent, i_exrom_line, i_game_line, i_port_unlock}),
    .o_sync({miso_s, wprot_s, absent_s, exrom_s, game_s, unlock_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and trigger
  // Full 16-bit compare, no mirrors
  assign hit_xchg = (i_addr == CSP_ADDR_EXCHANGE);
  assign hit_ctl = (i_addr == CSP_ADDR_CONTROL);
  assign hit_st = (i_addr == CSP_ADDR_STATUS);
  assign enabled = ~cur_ff.ctl[CSP_CTL_DISABLE]; // RULE2

  // Write or read of exchange register queues a byte per trigger mode
  always_comb
  begin
    push_valid = 1'b0;
    push_data = i_wdata;
    if (enabled && hit_xchg)
    begin
      // Write trigger sends the written byte
      if (!cur_ff.ctl[CSP_CTL_RD_TRIG] && i_wr) // RULE3
        push_valid = 1'b1; // RULE1
      else if (cur_ff.ctl[CSP_CTL_RD_TRIG] && i_rd) // RULE3
      begin
        // Read trigger sends a fill byte
        push_valid = 1'b1;
        push_data = CSP_FILL_BYTE;
      end
    end
  end

  // Host must hold off while the queue is full
  // A push into a full queue is dropped
  assign o_host_wait = ~push_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Outgoing byte queue
  csp_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(q_valid),
    .i_out_ready(q_ready),
    .o_out_data(q_data)
  );

  // Shifter takes a byte only when idle
  assign q_ready = (cur_ff.state == CSP_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Status and select terms
  assign half = cur_ff.ctl[CSP_CTL_FAST] ? CSP_HALF_FAST : CSP_HALF_SLOW; // RULE6
  assign sel = {cur_ff.ctl[CSP_CTL_SEL_HI], cur_ff.ctl[CSP_CTL_SEL_LO]};

  always_comb
  begin
    // Top bits and jumper bit read zero
    status = 8'h00;
    status[CSP_ST_JUMPER] = 1'b0; // RULE9
    status[CSP_ST_WPROT] = wprot_s; // RULE10
    status[CSP_ST_NOCARD] = absent_s; // RULE11
    status[CSP_ST_EXROM] = exrom_s;
    status[CSP_ST_GAME] = game_s;
    status[CSP_ST_BUSY] = ~cur_ff.ctl[CSP_CTL_FAST] & ((cur_ff.state != CSP_IDLE) | q_valid); // RULE12
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic: registers, chip selects and shifter
  always_comb
  begin
    nxt_st = cur_ff;

    // Control register write; bit 7 only while unlocked
    if (i_wr && hit_ctl)
    begin
      nxt_st.ctl = i_wdata;
      // Disable bit held while locked
      if (!unlock_s)
        nxt_st.ctl[CSP_CTL_DISABLE] = cur_ff.ctl[CSP_CTL_DISABLE]; // RULE2
    end
    // Status writes fall through with no effect (RULE8)

    // Read data, zero for unmapped addresses
    if (i_rd)
    begin
      if (hit_xchg)
        nxt_st.rdata = cur_ff.rx; // RULE1
      else if (hit_ctl)
        nxt_st.rdata = cur_ff.ctl;
      else if (hit_st)
        nxt_st.rdata = status;
      else
        nxt_st.rdata = 8'h00;
    end

    // One-hot chip select, none when disabled
    nxt_st.cs_n = 3'h7;
    if (enabled)
    begin
      unique case (sel) // RULE5
        CSP_SEL_CARD: nxt_st.cs_n[0] = 1'b0;
        CSP_SEL_FLASH: nxt_st.cs_n[1] = 1'b0;
        CSP_SEL_RTC: nxt_st.cs_n[2] = 1'b0;
        CSP_SEL_NONE: nxt_st.cs_n = 3'h7;
      endcase
    end

    // Mode 0 shifter, MSB first
    unique case (cur_ff.state)
      CSP_IDLE:
      begin
        // Clock low; load the next queued byte
        nxt_st.sck = 1'b0;
        if (q_valid)
        begin
          nxt_st.sh = q_data;
          nxt_st.mosi = q_data[7]; // RULE13
          nxt_st.bitn = 3'h0;
          nxt_st.cnt = 8'h01;
          nxt_st.state = CSP_SHIFT;
        end
      end
      CSP_SHIFT:
      begin
        // Count out one half period, then toggle sck
        if (cur_ff.cnt < half)
          nxt_st.cnt = cur_ff.cnt + 8'h01;
        else
        begin
          nxt_st.cnt = 8'h01;
          if (!cur_ff.sck)
          begin
            // Rising edge: sample incoming bit
            nxt_st.sck = 1'b1;
            nxt_st.rx = {cur_ff.rx[6:0], miso_s}; // RULE13
          end
          else
          begin
            // Falling edge: present next bit or finish
            nxt_st.sck = 1'b0;
            nxt_st.sh = {cur_ff.sh[6:0], 1'b0};
            nxt_st.mosi = cur_ff.sh[6]; // RULE13
            nxt_st.bitn = cur_ff.bitn + 3'h1;
            if (cur_ff.bitn == CSP_LAST_BIT)
            begin
              nxt_st.state = CSP_IDLE;
              nxt_st.mosi = 1'b1; // Data line idles high
            end
          end
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Shifter idle; rx reads ff until a byte arrives
      cur_ff.ctl <= CSP_CTL_RESET; // RULE14
      cur_ff.rx <= CSP_RX_RESET;
      cur_ff.sh <= 8'h00;
      cur_ff.rdata <= 8'h00;
      cur_ff.cnt <= 8'h00;
      cur_ff.bitn <= 3'h0;
      cur_ff.sck <= 1'b0; // RULE14
      cur_ff.mosi <= 1'b1;
      cur_ff.cs_n <= 3'h7; // RULE14
      cur_ff.state <= CSP_IDLE; // RULE14
    end
    else
      cur_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Read data and SPI pins
  assign o_rdata = cur_ff.rdata;
  assign o_spi_sck = cur_ff.sck;
  assign o_spi_mosi = cur_ff.mosi;

  // Chip selects, one per target
  assign o_card_cs_n = cur_ff.cs_n[0];
  assign o_flash_cs_n = cur_ff.cs_n[1];
  assign o_rtc_cs_n = cur_ff.cs_n[2];

  // ROM banking from control bits 0 and 5
  assign o_boot_rom_map = ~cur_ff.ctl[CSP_CTL_BOOT_OFF]; // RULE7
  assign o_ext_rom_en = cur_ff.ctl[CSP_CTL_BOOT_OFF] & ~cur_ff.ctl[CSP_CTL_EXT_OFF]; // RULE4

endmodule : csp_port
`default_nettype wire

// >>> tb/csp_port_monitor.sv
// Purpose: Port assertions for the SPI host port
// Assumes: One clock domain, reset active high
// Notes: Bound to every csp_port instance
`timescale 1ns/1ps
`default_nettype none
module csp_port_monitor
  import csp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_port_unlock,
  input wire logic o_boot_rom_map,
  input wire logic o_ext_rom_en,
  input wire logic o_spi_sck,
  input wire logic o_spi_mosi,
  input wire logic o_card_cs_n,
  input wire logic o_flash_cs_n,
  input wire logic o_rtc_cs_n
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Decoded control writes and expected pin levels
  wire logic wr_ctl = i_wr && i_addr == CSP_ADDR_CONTROL;
  wire logic [2:0] cs = {o_card_cs_n, o_flash_cs_n, o_rtc_cs_n};
  wire logic [2:0] cs_exp = {i_wdata[4] | i_wdata[1], !i_wdata[4] | i_wdata[1], !(i_wdata[4] & i_wdata[1])};
  wire logic [1:0] rom_exp = {!i_wdata[0], i_wdata[0] & !i_wdata[5]};
  ////////////////////////////////////////////////////////////////////////////////
  AST_RST_IDLE: assert property ($past(i_rst) |-> !o_spi_sck && cs == 3'h7)
    else $error("idle after reset");
  AST_ONE_CS: assert property ($onehot0(~cs))
    else $error("two selects");
  AST_CS_DECODE: assert property (wr_ctl && !i_wdata[7] && i_port_unlock |-> ##2 cs == $past(cs_exp, 2))
    else $error("select decode");
  AST_DISABLE: assert property (wr_ctl && i_wdata[7] && i_port_unlock |-> ##2 cs == 3'h7)
    else $error("disable");
  AST_ROM: assert property (wr_ctl |=> {o_boot_rom_map, o_ext_rom_en} == $past(rom_exp))
    else $error("rom map");
  AST_ST_ZERO: assert property (i_rd && i_addr == CSP_ADDR_STATUS |=> o_rdata[7:5] == 3'h0)
    else $error("status top bits");
  AST_SCK_HI: assert property ($rose(o_spi_sck) |-> o_spi_sck[*4])
    else $error("sck too fast");
  AST_MOSI: assert property (o_spi_sck |-> $stable(o_spi_mosi))
    else $error("mosi moved");
  // Main scenarios seen
  C_SHIFT: cover property ($rose(o_spi_sck));
  C_DIS: cover property (wr_ctl && i_wdata[7] && i_port_unlock);
  C_ST: cover property (i_rd && i_addr == CSP_ADDR_STATUS);
endmodule : csp_port_monitor
bind csp_port csp_port_monitor u_csp_port_monitor (.i_mclk, .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
  .i_port_unlock, .o_boot_rom_map, .o_ext_rom_en, .o_spi_sck, .o_spi_mosi, .o_card_cs_n, .o_flash_cs_n, .o_rtc_cs_n);
`default_nettype wire

// >>> tb/csp_card_model.sv
// Purpose: Card side of the SPI link
// Assumes: Mode 0, MSB first, eight clocks a byte
// Notes: Replies with the inverse of the byte last taken
`timescale 1ns/1ps
`default_nettype none
module csp_card_model (
  input wire logic i_mclk,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_cs_n,
  output logic o_miso,
  output logic [7:0] o_got,
  output logic [2:0] o_cnt
);
  logic [7:0] rx = 8'h00, tx = 8'ha5, got = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic bit_o = 1'b1, tgl = 1'b0;
  // Take a bit on each rising edge while selected
  always @(posedge i_sck)
    if (!i_cs_n)
    begin
      rx = {rx[6:0], i_mosi};
      cnt = cnt + 3'h1;
      if (cnt == 3'h0)
      begin
        got = rx;
        tx = ~rx;
      end
    end
  // Next bit on each falling edge
  always @(negedge i_sck)
    if (!i_cs_n)
      bit_o = tx[3'h7 - cnt];
  // Line wobbles while deselected
  always @(posedge i_mclk)
    tgl <= ~tgl;
  assign o_miso = i_cs_n ? tgl : bit_o;
  assign o_got = got;
  assign o_cnt = cnt;
endmodule : csp_card_model
`default_nettype wire

// >>> tb/test_card_spi_host_port.sv
// Purpose: Self-checking bench for the SPI host port
// Assumes: Card model answers on the SPI side
// Notes: Expected bytes wait in queues for watchers
`timescale 1ns/1ps
`default_nettype none
module test_card_spi_host_port
  import csp_pkg::*;
();
  logic clk = 0, rst = 1, wr = 0, rd = 0, unl = 1, wp = 0, ab = 0, ex = 0, gm = 0, rd_seen = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdata, got, reply = 8'ha5, rx_exp = 8'hff;
  logic hw, boot, ext, sck, mosi, miso, ccs, fcs, rcs;
  logic [2:0] cnt;
  logic [7:0] rq[$], cq[$];
  logic [2:0] cs_tab[4] = '{3'h3, 3'h7, 3'h5, 3'h6};
  int bad_count = 0, checks = 0, cyc = 0, seed = 32'h8cf0, n = 0;
  // Bus clock
  always #10 clk = ~clk;
  csp_port u_csp_port (.i_mclk(clk), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wd),
    .o_rdata(rdata), .o_host_wait(hw), .i_port_unlock(unl), .o_boot_rom_map(boot), .o_ext_rom_en(ext),
    .o_spi_sck(sck), .o_spi_mosi(mosi), .i_spi_miso(miso), .o_card_cs_n(ccs), .o_flash_cs_n(fcs),
    .o_rtc_cs_n(rcs), .i_card_wprot(wp), .i_card_absent(ab), .i_exrom_line(ex), .i_game_line(gm));
  csp_card_model u_csp_card_model (.i_mclk(clk), .i_sck(sck), .i_mosi(mosi), .i_cs_n(ccs), .o_miso(miso),
    .o_got(got), .o_cnt(cnt));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Read data against the oldest noted value
  task automatic chk_read(input logic [7:0] g);
    chk(g, rq.pop_front());
  endtask : chk_read
  // Byte landing at the card against the oldest noted byte
  task automatic chk_byte(input logic [7:0] g);
    chk(g, cq.pop_front());
  endtask : chk_byte
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
  endtask : acc
  task automatic rdx(input logic [15:0] a, input logic [7:0] e);
    rq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rdx
  task automatic snd(input logic [7:0] d);
    cq.push_back(d);
    rx_exp = reply;
    reply = ~d;
    acc(1'b1, CSP_ADDR_EXCHANGE, d);
  endtask : snd
  task automatic trig;
    cq.push_back(CSP_FILL_BYTE);
    rdx(CSP_ADDR_EXCHANGE, rx_exp);
    rx_exp = reply;
    reply = ~CSP_FILL_BYTE;
  endtask : trig
  task automatic drain;
    while (cq.size() != 0)
      @(negedge clk);
  endtask : drain
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Read strobes seen by the port
  always @(posedge clk)
    rd_seen <= rd;
  // Read data against oldest note
  always @(negedge clk)
    if (rd_seen)
      chk_read(rdata);
  // Bytes landing at the card
  always @(negedge sck)
    if (!ccs && cnt == 3'h0)
      chk_byte(got);
  // Cycle limit against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 0;
    chk({4'h0, sck, ccs, fcs, rcs}, 8'h07);
    rdx(CSP_ADDR_CONTROL, CSP_CTL_RESET);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      {wp, ab, ex, gm} = 4'($random(seed));
      repeat (3) @(negedge clk);
      acc(1'b1, CSP_ADDR_STATUS, 8'hff);
      rdx(CSP_ADDR_STATUS, {3'h0, wp, ab, ex, gm, 1'b0});
    end
    $display("test status done");
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, CSP_ADDR_CONTROL, {2'h0, i[2], i[3], 2'h0, i[1], i[0]});
      @(negedge clk);
      chk({5'h0, ccs, fcs, rcs}, {5'h0, cs_tab[{i[3], i[1]}]});
      chk({6'h0, boot, ext}, {6'h0, !i[0], i[0] & !i[2]});
      rdx(CSP_ADDR_CONTROL, {2'h0, i[2], i[3], 2'h0, i[1], i[0]});
    end
    $display("test control done");
    unl = 0;
    repeat (2) @(negedge clk);
    acc(1'b1, CSP_ADDR_CONTROL, 8'h80);
    rdx(CSP_ADDR_CONTROL, 8'h00);
    unl = 1;
    repeat (2) @(negedge clk);
    acc(1'b1, CSP_ADDR_CONTROL, 8'h80);
    unl = 0;
    repeat (2) @(negedge clk);
    acc(1'b1, CSP_ADDR_CONTROL, 8'h04);
    acc(1'b1, CSP_ADDR_EXCHANGE, 8'h5a);
    rdx(CSP_ADDR_CONTROL, 8'h84);
    repeat (8) @(negedge clk);
    chk({4'h0, sck, ccs, fcs, rcs}, 8'h07);
    unl = 1;
    repeat (2) @(negedge clk);
    acc(1'b1, CSP_ADDR_CONTROL, 8'h04);
    $display("test lock done");
    for (int i = 0; i < 17; i++)
      snd(8'($random(seed)));
    chk({7'h0, hw}, 8'h01);
    acc(1'b1, CSP_ADDR_EXCHANGE, 8'h77);
    rdx(CSP_ADDR_STATUS, {3'h0, wp, ab, ex, gm, 1'b0});
    drain();
    chk({7'h0, hw}, 8'h00);
    rdx(CSP_ADDR_EXCHANGE, rx_exp);
    $display("test fast done");
    acc(1'b1, CSP_ADDR_CONTROL, 8'h00);
    snd(8'hc3);
    rdx(CSP_ADDR_STATUS, {3'h0, wp, ab, ex, gm, 1'b1});
    @(posedge sck);
    @(negedge clk);
    while (sck)
    begin
      n++;
      @(negedge clk);
    end
    chk(8'(n), CSP_HALF_SLOW);
    drain();
    rdx(CSP_ADDR_STATUS, {3'h0, wp, ab, ex, gm, 1'b0});
    rdx(CSP_ADDR_EXCHANGE, rx_exp);
    $display("test slow done");
    acc(1'b1, CSP_ADDR_CONTROL, 8'h44);
    trig();
    acc(1'b1, CSP_ADDR_EXCHANGE, 8'h33);
    drain();
    trig();
    drain();
    $display("test trigger done");
    stop_test();
  end
endmodule : test_card_spi_host_port
`default_nettype wire
